//--- shared/fieldbus_master_watchdog_cfg.svh
`ifndef FIELDBUS_MASTER_WATCHDOG_CFG_SVH
`define FIELDBUS_MASTER_WATCHDOG_CFG_SVH

// Core clock period in ns (50 MHz)
`define CORE_CLK_PERIOD_NS 20
// One millisecond in ns, the tick of all supervision timing
`define MS_TIME_NS 1000000
// Cycles per millisecond tick, derived from the clock period
`define MS_CYCLES (`MS_TIME_NS / `CORE_CLK_PERIOD_NS)
// Off delay of the communication warning, in seconds as printed
`define WARN_HOLD_S 2
// Off delay expressed in millisecond ticks
`define WARN_HOLD_MS (`WARN_HOLD_S * 1000)
// Width of the interval setting in ms and of the timers
`define TIMER_W 16
// Reset values
`define TIMER_RST 16'h0000

`endif

//--- shared/fieldbus_master_watchdog_pkg.sv
`include "fieldbus_master_watchdog_cfg.svh"

package fieldbus_master_watchdog_pkg;

	// Supervision phases: disarmed, watching, timed out
	typedef enum logic [1:0] {
		SUP_IDLE,
		SUP_WATCH,
		SUP_FAULT
	} sup_state_t;

	typedef logic [`TIMER_W-1:0] timer_t;

	// Saturating increment so long silences never wrap to a small count
	function automatic timer_t sat_inc(input timer_t val);
		timer_t res;
		res = val;
		if (val != {`TIMER_W{1'b1}}) begin
			res = val + timer_t'(1);
		end
		return res;
	endfunction : sat_inc

endpackage : fieldbus_master_watchdog_pkg

//--- logic/warn_hold_timer.sv
`timescale 1ns/100ps
`include "fieldbus_master_watchdog_cfg.svh"

module warn_hold_timer
	import fieldbus_master_watchdog_pkg::*;
#(
	parameter int unsigned HOLD_MS = `WARN_HOLD_MS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Timing and control
	input wire logic tick_ms,
	input wire logic cause,
	input wire logic clear,
	// Held warning
	output logic warn
);

	logic warn_reg;
	timer_t hold_cnt_reg;

	assign warn = warn_reg;

	// Count whole ticks after the cause drops; one extra tick covers
	// the partial first millisecond so the hold is never short
	always_ff @(posedge core_clk) begin
		if (!rst_b || clear) begin
			warn_reg <= 1'b0;
			hold_cnt_reg <= `TIMER_RST;
		end else if (cause) begin
			warn_reg <= 1'b1;
			hold_cnt_reg <= `TIMER_RST;
		end else if (warn_reg && tick_ms) begin
			if (hold_cnt_reg == timer_t'(HOLD_MS)) begin
				warn_reg <= 1'b0;
			end else begin
				hold_cnt_reg <= sat_inc(hold_cnt_reg);
			end
		end
	end

	// The warning may not drop while the hold count is still short
	a_hold_keeps_warn: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(warn_reg && !cause && !clear && hold_cnt_reg < timer_t'(HOLD_MS))
		|=> warn_reg)
		else $error("warning dropped before hold time");

	// Once the hold count is full the next tick must release it
	a_hold_release: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(warn_reg && !cause && !clear && tick_ms &&
		hold_cnt_reg == timer_t'(HOLD_MS)) |=> !warn_reg)
		else $error("warning not released after hold time");

endmodule : warn_hold_timer

//--- logic/fieldbus_master_watchdog.sv
`timescale 1ns/100ps
`include "fieldbus_master_watchdog_cfg.svh"

module fieldbus_master_watchdog
	import fieldbus_master_watchdog_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `MS_CYCLES,
	parameter int unsigned HOLD_MS = `WARN_HOLD_MS
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Configuration, interval in ms
	input wire logic [`TIMER_W-1:0] comm_supervision_interval,
	// Process-data exchange from the fieldbus side
	input wire logic xchg_strobe,
	input wire logic xchg_ok,
	input wire logic xchg_data_valid,
	// Towards the drive control state machine
	output logic drive_inhibit_req,
	// Status
	output logic comm_warning,
	output logic comm_fault,
	output logic sup_armed
);

	sup_state_t state_reg;
	sup_state_t state_next;
	timer_t elapsed_reg;
	timer_t elapsed_inc;
	logic [15:0] pre_reg;
	logic tick_ms;
	logic good_xchg;
	logic sup_off;
	logic timeout;
	logic force_reg;

	// Only an error-free exchange carrying valid master data counts;
	// a stopped master marks its outputs invalid
	assign good_xchg = xchg_strobe && xchg_ok && xchg_data_valid;
	assign sup_off = (comm_supervision_interval == `TIMER_RST);
	assign elapsed_inc = sat_inc(elapsed_reg);
	assign tick_ms = (pre_reg == 16'(MS_CYCLES - 1));

	// Window expires at the tick that reaches the interval; >= also
	// catches an interval lowered below the running count
	assign timeout = tick_ms && !good_xchg &&
		(elapsed_inc >= comm_supervision_interval);

	// Free running millisecond prescaler shared by both timers
	always_ff @(posedge core_clk) begin
		if (!rst_b || tick_ms) begin
			pre_reg <= 16'h0000;
		end else begin
			pre_reg <= pre_reg + 16'h0001;
		end
	end

	// Supervision phase selection
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SUP_IDLE: begin
				if (!sup_off && good_xchg) begin
					state_next = SUP_WATCH;
				end
			end
			SUP_WATCH: begin
				if (sup_off) begin
					state_next = SUP_IDLE;
				end else if (timeout) begin
					state_next = SUP_FAULT;
				end
			end
			SUP_FAULT: begin
				if (sup_off) begin
					state_next = SUP_IDLE;
				end else if (good_xchg) begin
					state_next = SUP_WATCH;
				end
			end
			default: begin
				state_next = SUP_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_reg <= SUP_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Time since the last good exchange, in ms ticks
	always_ff @(posedge core_clk) begin
		if (!rst_b || sup_off || state_reg == SUP_IDLE) begin
			elapsed_reg <= `TIMER_RST;
		end else if (good_xchg) begin
			elapsed_reg <= `TIMER_RST;
		end else if (tick_ms) begin
			elapsed_reg <= elapsed_inc;
		end
	end

	// One request per timeout; the drive logic latches the inhibit
	// itself, so repeating it every cycle would add nothing
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			force_reg <= 1'b0;
		end else begin
			force_reg <= (state_reg == SUP_WATCH) && !sup_off && timeout;
		end
	end

	// Warning follows the fault and lingers for diagnostics
	warn_hold_timer #(
		.HOLD_MS(HOLD_MS)
	) u_warn_hold (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.tick_ms(tick_ms),
		.cause(state_reg == SUP_FAULT),
		.clear(sup_off),
		.warn(comm_warning)
	);

	// Fault and armed status decode straight from the phase register; the inhibit request is force_reg
	assign drive_inhibit_req = force_reg;
	assign comm_fault = (state_reg == SUP_FAULT);
	assign sup_armed = (state_reg != SUP_IDLE);

	// Nothing but a good exchange may arm the supervision
	a_arm_on_good: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(state_reg == SUP_IDLE && !good_xchg) |=> state_reg == SUP_IDLE)
		else $error("supervision armed without a good exchange");

	// While disarmed the block stays silent towards the drive
	a_idle_quiet: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!sup_armed |-> (!comm_fault && !drive_inhibit_req && !comm_warning))
		else $error("output active while supervision disarmed");

	// Once armed, only a zero interval disarms again
	a_armed_stays: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(sup_armed && !sup_off) |=> sup_armed)
		else $error("supervision disarmed without a zero interval");

	// A timeout never comes before the window has run out
	a_early_trip: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		force_reg |-> $past(elapsed_inc) >= $past(comm_supervision_interval))
		else $error("timeout raised before the interval elapsed");

	// Timeout: inhibit pulse and fault at once, warning one edge later
	a_timeout_force: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(state_reg == SUP_WATCH && !sup_off && timeout)
		|=> (state_reg == SUP_FAULT && drive_inhibit_req)
		##1 comm_warning)
		else $error("timeout did not force inhibit and warning");

	// The inhibit request is a single pulse per timeout
	a_inhibit_pulse: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		drive_inhibit_req |=> !drive_inhibit_req)
		else $error("inhibit request longer than one cycle");

	// A standing fault raises no further inhibit requests
	a_fault_no_repeat: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(comm_fault && !good_xchg && !sup_off)
		|=> (comm_fault && !drive_inhibit_req))
		else $error("inhibit repeated during a standing fault");

	// A standing fault keeps the warning up
	a_fault_warns: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(comm_fault && !sup_off) |=> comm_warning)
		else $error("fault present without a warning");

	// A zero interval clears everything within one edge
	a_zero_disables: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		sup_off |=> (state_reg == SUP_IDLE && !drive_inhibit_req &&
		!comm_warning))
		else $error("supervision active with zero interval");

	// Invalid or erroneous data must not restart the window
	a_invalid_ignored: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(state_reg == SUP_WATCH && !sup_off && !good_xchg &&
		elapsed_reg != `TIMER_RST) |=> elapsed_reg != `TIMER_RST)
		else $error("invalid data restarted the window");

	// A good exchange restarts the window and ends a fault
	a_good_restart: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(good_xchg && !sup_off) |=> (elapsed_reg == `TIMER_RST &&
		state_reg == SUP_WATCH))
		else $error("good exchange did not restart the timer");

	// Main scenarios: arm, timeout, recovery, warning expiry, disable
	c_arm: cover property (@(posedge core_clk) disable iff (!rst_b)
		$rose(sup_armed));
	c_timeout: cover property (@(posedge core_clk) disable iff (!rst_b)
		drive_inhibit_req);
	c_recover: cover property (@(posedge core_clk) disable iff (!rst_b)
		state_reg == SUP_FAULT ##1 state_reg == SUP_WATCH);
	c_warn_off: cover property (@(posedge core_clk) disable iff (!rst_b)
		$fell(comm_warning) && !sup_off);
	c_disable: cover property (@(posedge core_clk) disable iff (!rst_b)
		$fell(sup_armed));

endmodule : fieldbus_master_watchdog

//--- dv/fieldbus_master_model.sv
`timescale 1ns/100ps

module fieldbus_master_model (
	// Clock
	input wire logic core_clk,
	// Exchange request from the bench
	input wire logic req,
	input wire logic req_ok,
	input wire logic req_valid,
	// Process-data exchange towards the block
	output logic xchg_strobe = 1'b0,
	output logic xchg_ok = 1'b0,
	output logic xchg_data_valid = 1'b0
);
	// One strobe per request; qualifiers toggle outside a frame so stale
	// values never look like a fresh exchange
	always @(posedge core_clk) begin
		xchg_strobe <= req;
		xchg_ok <= req ? req_ok : ~xchg_ok;
		xchg_data_valid <= req ? req_valid : ~xchg_data_valid;
	end
endmodule : fieldbus_master_model

//--- dv/tb.sv
`timescale 1ns/100ps
`include "fieldbus_master_watchdog_cfg.svh"

module tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic req = 1'b0;
	logic req_ok = 1'b0;
	logic req_valid = 1'b0;
	logic [`TIMER_W-1:0] ival = 16'h0008;
	logic xchg_strobe, xchg_ok, xchg_data_valid;
	logic drive_inhibit_req, comm_warning, comm_fault, sup_armed;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;

	// Free-running 50 MHz clock
	initial begin
		forever #10 core_clk = ~core_clk;
	end

	fieldbus_master_model u_master (.core_clk(core_clk), .req(req),
		.req_ok(req_ok), .req_valid(req_valid), .xchg_strobe(xchg_strobe),
		.xchg_ok(xchg_ok), .xchg_data_valid(xchg_data_valid));

	// Short tick and hold so the run stays a few hundred cycles
	fieldbus_master_watchdog #(.MS_CYCLES(4), .HOLD_MS(3)) u_dut (
		.core_clk(core_clk), .rst_b(rst_b),
		.comm_supervision_interval(ival), .xchg_strobe(xchg_strobe),
		.xchg_ok(xchg_ok), .xchg_data_valid(xchg_data_valid),
		.drive_inhibit_req(drive_inhibit_req), .comm_warning(comm_warning),
		.comm_fault(comm_fault), .sup_armed(sup_armed));

	task automatic stop_test;
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %b seen %b", what, exp, got);
		end
	endtask : chk

	// Sample just past the edge so its updates have landed
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask : tick

	// Returns once the block has taken the exchange
	task automatic send(input logic ok, input logic vld);
		@(posedge core_clk);
		req <= 1'b1;
		req_ok <= ok;
		req_valid <= vld;
		@(posedge core_clk);
		req <= 1'b0;
		tick(1);
	endtask : send

	task automatic wait_inh(input int lim, output int k);
		k = 0;
		while (drive_inhibit_req !== 1'b1 && k < lim) begin
			tick(1);
			k++;
		end
	endtask : wait_inh

	task automatic t_disarmed;
		send(1'b1, 1'b0);
		send(1'b0, 1'b1);
		wait_inh(40, n);
		chk("sup_armed", 1'b0, sup_armed);
		chk("drive_inhibit_req", 1'b0, drive_inhibit_req);
		chk("comm_warning", 1'b0, comm_warning);
	endtask : t_disarmed

	task automatic t_timeout;
		send(1'b1, 1'b1);
		chk("sup_armed", 1'b1, sup_armed);
		repeat (6) begin
			tick(10);
			send(1'b1, 1'b1);
		end
		chk("comm_fault", 1'b0, comm_fault);
		wait_inh(40, n);
		chk("timeout not early", 1'b1, n >= 27);
		chk("timeout not late", 1'b1, n <= 33);
		chk("comm_fault", 1'b1, comm_fault);
		tick(1);
		chk("inhibit pulse end", 1'b0, drive_inhibit_req);
		chk("comm_warning", 1'b1, comm_warning);
		send(1'b1, 1'b1);
		chk("comm_fault", 1'b0, comm_fault);
		tick(10);
		chk("warning held", 1'b1, comm_warning);
		tick(7);
		chk("warning released", 1'b0, comm_warning);
	endtask : t_timeout

	// A good exchange opens a 32 cycle window; the wait starts 21 cycles
	// in, so the timeout must show within 11 unless bad data restarted it
	task automatic t_invalid;
		send(1'b1, 1'b1);
		repeat (3) begin
			tick(3);
			send(1'b1, 1'b0);
		end
		send(1'b0, 1'b1);
		wait_inh(40, n);
		chk("drive_inhibit_req", 1'b1, drive_inhibit_req);
		chk("window from good exchange", 1'b1, n <= 11);
		chk("comm_fault", 1'b1, comm_fault);
	endtask : t_invalid

	task automatic t_zero;
		@(posedge core_clk);
		ival <= 16'h0000;
		tick(2);
		chk("sup_armed", 1'b0, sup_armed);
		chk("comm_warning", 1'b0, comm_warning);
		send(1'b1, 1'b1);
		wait_inh(50, n);
		chk("drive_inhibit_req", 1'b0, drive_inhibit_req);
		chk("sup_armed", 1'b0, sup_armed);
	endtask : t_zero

	// Main sequence after five reset cycles
	initial begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		t_disarmed();
		t_timeout();
		t_invalid();
		t_zero();
		stop_test();
	end

	// Hang guard, far above the few hundred cycles the tests need
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			stop_test();
		end
	end
endmodule : tb
